/* File: rtl/dtf_cyl_mem.sv */
// per-drive cylinder copy memory with registered read
`timescale 1ns/1ps
module dtf_cyl_mem #(
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic          clk,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [9:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [9:0]    rdata
);
	logic [9:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
		if (ce) begin
			rdata <= mem[raddr];
		end
	end
endmodule : dtf_cyl_mem

/* File: rtl/dtf_pkg.sv */
// package of constants and carrier types for the disk task file block
package dtf_pkg;
	// ************************************************************
	// register codes on the three address lines
	// ************************************************************
	localparam logic [2:0] ADR_DATA   = 3'h0;
	localparam logic [2:0] ADR_ERRPRE = 3'h1;
	localparam logic [2:0] ADR_SCNT   = 3'h2;
	localparam logic [2:0] ADR_SNUM   = 3'h3;
	localparam logic [2:0] ADR_CYLLO  = 3'h4;
	localparam logic [2:0] ADR_CYLHI  = 3'h6;
	localparam logic [2:0] ADR_SDH    = 3'h7;

	// ************************************************************
	// size/drive/head fields
	// ************************************************************
	localparam int SDH_ECC_BIT = 7;
	localparam int SDH_SIZE_HI = 6;
	localparam int SDH_SIZE_LO = 5;
	localparam int SDH_DRV_HI  = 4;
	localparam int SDH_DRV_LO  = 3;
	localparam int SDH_HEAD_HI = 2;
	localparam logic [1:0] SIZE_256 = 2'h0;
	localparam logic [1:0] SIZE_512 = 2'h1;
	localparam logic [1:0] SIZE_RSV = 2'h2;
	localparam logic [1:0] SIZE_128 = 2'h3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] STAT_BUSY = 8'h80;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS        = 40;
	localparam int DIR_SETUP_NS  = 250;
	localparam int STEP_WIDTH_NS = 5000;
	localparam int DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STEP_WIDTH_CYC = STEP_WIDTH_NS / CLK_NS;
	localparam int TCLK_DIV      = 64;
	localparam int SETTLE_INDEX  = 128;
	localparam int PRECOMP_NS    = 12;

	typedef struct packed {
		logic       ecc;
		logic [1:0] size;
		logic [1:0] drive;
		logic [2:0] head;
	} dtf_sdh_s;
endpackage : dtf_pkg

/* File: rtl/dtf_task_file.sv */
// task file registers and drive-side timing of the disk controller
// ************************************************************
// What this block does
// - drive timing clock and complement at write crystal over 64 per link.
// - per-drive selected indication is ignored entirely.
// - chip select low plus A2-A0 picks the register; high deselects.
// - command write clears interrupt request; command is write-only.
// - status loaded at command finish; busy hides other bits.
// - any status access clears interrupt request.
// - status is read-only; a write at its address is the command and loads busy.
// - size/drive/head holds check select, size, drive and head fields.
// - cylinder is high two bits above eight low bits.
// - each of four drives keeps its own cylinder copy.
// - sector count decrements per finished sector; host reloads it.
// - read-only error register holds last command fault detail.
// - precomp register times four is the threshold for current and precomp.
// - precompensation shifts write transitions by a fixed delay.
// - each data register access while a transfer is requested moves one byte of the buffer.
// - each drive has its own unshared write data path.
// - write gate lasts one sector time to two rotations.
// - direction set 250 ns before step; step lasts 5 us.
// - programmed step pulses spaced by the selected period.
// - auto-restore steps wait for seek complete from the drive.
// - after the last step wait seek complete up to 127 index pulses.
// - direction high for outward motion, low for inward.
// - one step pulse per cylinder moved.
// ************************************************************
`timescale 1ns/1ps
module dtf_task_file #(
	parameter int STEP_SPACE_CYC = 12500
) (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       CE,
	input  wire logic       WCLK,
	input  wire logic       CS_N,
	input  wire logic [2:0] ADDR,
	input  wire logic       RD_N,
	input  wire logic       WR_N,
	input  wire logic [7:0] DIN,
	output logic      [7:0] DOUT,
	output logic            DOUT_OE_N,
	input  wire logic       SDH_AT_TOP,
	output logic            INTERRUPT_REQUEST_OUT,
	output logic            DATA_REQUEST_LINE,
	input  wire logic       CMD_DONE,
	input  wire logic [7:0] CMD_STATUS,
	input  wire logic [7:0] CMD_FAULT,
	input  wire logic       SECTOR_DONE,
	input  wire logic       BUF_REQ,
	output logic            BUF_RD,
	output logic            BUF_WR,
	output logic      [7:0] BUF_WDATA,
	input  wire logic [7:0] BUF_RDATA,
	input  wire logic       WRITE_REQ,
	input  wire logic       SECTOR_TIME_DONE,
	input  wire logic       ROTATION_PULSE,
	output logic            WRITE_GATE,
	input  wire logic       SEEK_START,
	input  wire logic [9:0] SEEK_COUNT,
	input  wire logic       SEEK_OUT,
	input  wire logic       AUTO_RESTORE,
	input  wire logic       SEEK_COMPLETE_PIN,
	input  wire logic       INDEX_PIN,
	output logic            STEP,
	output logic            DIRECTION_OUT,
	output logic            SEEK_TIMEOUT,
	output logic            SEEK_DONE,
	output logic            REDUCED_WRITE_CURRENT,
	output logic            PRECOMP_ENABLE,
	output logic      [9:0] TARGET_CYLINDER,
	output dtf_pkg::dtf_sdh_s SIZE_DRIVE_HEAD_SELECT,
	output logic      [1:0] SECTOR_SIZE_SEL,
	output logic            SIZE_RESERVED,
	input  wire logic [3:0] DRIVE_SELECTED_IN,
	input  wire logic [3:0] MFM_WDATA_RAW,
	output logic      [3:0] MFM_WDATA_P,
	output logic      [3:0] MFM_WDATA_N,
	output logic      [3:0] TIMING_CLK_P,
	output logic      [3:0] TIMING_CLK_N
);
	// ************************************************************
	// pin synchronisers and host strobe edges
	// ************************************************************
	logic [2:0] sync1_r, sync2_r;
	logic       rd_prev_r, wr_prev_r, idx_prev_r;
	always_ff @(posedge CLK) begin
		if (RST) begin
			// index idles low, so a high reset value would fake an edge
			sync1_r <= 3'h6;
			sync2_r <= 3'h6;
		end else if (CE) begin
			sync1_r <= {RD_N, WR_N, INDEX_PIN};
			sync2_r <= sync1_r;
		end
	end
	wire rd_n_s = sync2_r[2];
	wire wr_n_s = sync2_r[1];
	wire idx_s  = sync2_r[0];
	logic       sc1_r, sc2_r;
	always_ff @(posedge CLK) begin
		if (RST) begin
			sc1_r <= 1'b0;
			sc2_r <= 1'b0;
		end else if (CE) begin
			sc1_r <= SEEK_COMPLETE_PIN;
			sc2_r <= sc1_r;
		end
	end
	wire seek_cmp_s = sc2_r;

	// chip select and address are held stable across a strobe
	wire sel     = ~CS_N;
	wire rd_edge = sel && rd_prev_r && !rd_n_s;
	wire wr_edge = sel && wr_prev_r && !wr_n_s;
	wire at_top  = ADDR == dtf_pkg::ADR_SDH;
	wire top_sdh = at_top && SDH_AT_TOP;
	wire top_cmd = at_top && !SDH_AT_TOP;
	wire idx_edge = idx_s && !idx_prev_r;

	// ************************************************************
	// task file registers
	// ************************************************************
	logic [7:0] scnt_r, snum_r, cyllo_r, cylhi_r, sdh_r, pre_r;
	logic [7:0] stat_r, err_r, cmd_r, dout_r;
	logic       irq_r;
	wire sdh_wr  = wr_edge && top_sdh;
	wire cyl_wr  = wr_edge && (ADDR == dtf_pkg::ADR_CYLLO
	                        || ADDR == dtf_pkg::ADR_CYLHI);
	wire cmd_wr  = wr_edge && top_cmd;
	wire stat_rd = rd_edge && top_cmd;
	wire data_rd = rd_edge && ADDR == dtf_pkg::ADR_DATA;
	wire data_wr = wr_edge && ADDR == dtf_pkg::ADR_DATA;

	always_ff @(posedge CLK) begin
		if (RST) begin
			rd_prev_r  <= 1'b1;
			wr_prev_r  <= 1'b1;
			idx_prev_r <= 1'b0;
		end else if (CE) begin
			rd_prev_r  <= rd_n_s;
			wr_prev_r  <= wr_n_s;
			idx_prev_r <= idx_s;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			scnt_r  <= dtf_pkg::REG_RESET;
			snum_r  <= dtf_pkg::REG_RESET;
			cyllo_r <= dtf_pkg::REG_RESET;
			cylhi_r <= dtf_pkg::REG_RESET;
			sdh_r   <= dtf_pkg::REG_RESET;
			pre_r   <= dtf_pkg::REG_RESET;
			cmd_r   <= dtf_pkg::REG_RESET;
		end else if (CE && wr_edge) begin
			case (ADDR)
			dtf_pkg::ADR_ERRPRE: pre_r   <= DIN;
			dtf_pkg::ADR_SCNT:   scnt_r  <= DIN;
			dtf_pkg::ADR_SNUM:   snum_r  <= DIN;
			dtf_pkg::ADR_CYLLO:  cyllo_r <= DIN;
			dtf_pkg::ADR_CYLHI:  cylhi_r <= DIN;
			dtf_pkg::ADR_SDH: begin
				if (SDH_AT_TOP) begin
					sdh_r <= DIN;
				end else begin
					cmd_r <= DIN;
				end
			end
			default: ;
			endcase
		end
		// only a reload of the count itself may swallow a finished sector
		if (!RST && CE && SECTOR_DONE && scnt_r != 8'h00
		    && !(wr_edge && ADDR == dtf_pkg::ADR_SCNT)) begin
			scnt_r <= scnt_r - 8'h01;
		end
	end

	// fault is loaded only by the engine; status also takes busy on a host command write
	always_ff @(posedge CLK) begin
		if (RST) begin
			stat_r <= dtf_pkg::REG_RESET;
			err_r  <= dtf_pkg::REG_RESET;
		end else if (CE) begin
			if (CMD_DONE) begin
				stat_r <= CMD_STATUS;
				err_r  <= CMD_FAULT;
			end else if (cmd_wr) begin
				stat_r <= dtf_pkg::STAT_BUSY;
			end
		end
	end

	// a finishing command wins over a clearing access in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_r <= 1'b0;
		end else if (CE) begin
			if (CMD_DONE) begin
				irq_r <= 1'b1;
			end else if (cmd_wr || (sel && at_top && !SDH_AT_TOP
			             && (rd_edge || wr_edge))) begin
				irq_r <= 1'b0;
			end
		end
	end

	// ************************************************************
	// read path and sector buffer port
	// ************************************************************
	logic [7:0] rd_mux;
	always_comb begin
		case (ADDR)
		dtf_pkg::ADR_DATA:   rd_mux = BUF_RDATA;
		dtf_pkg::ADR_ERRPRE: rd_mux = err_r;
		dtf_pkg::ADR_SCNT:   rd_mux = scnt_r;
		dtf_pkg::ADR_SNUM:   rd_mux = snum_r;
		dtf_pkg::ADR_CYLLO:  rd_mux = cyllo_r;
		dtf_pkg::ADR_CYLHI:  rd_mux = cylhi_r;
		dtf_pkg::ADR_SDH:    rd_mux = SDH_AT_TOP ? sdh_r : stat_r;
		default:             rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			dout_r <= 8'h00;
		end else if (CE && rd_edge) begin
			dout_r <= rd_mux;
		end
	end
	assign DOUT      = dout_r;
	assign DOUT_OE_N = !(sel && !rd_n_s);
	assign INTERRUPT_REQUEST_OUT = irq_r;
	assign DATA_REQUEST_LINE     = BUF_REQ;
	// one byte per access, only while a transfer is requested
	assign BUF_RD    = data_rd && BUF_REQ;
	assign BUF_WR    = data_wr && BUF_REQ;
	assign BUF_WDATA = DIN;

	// ************************************************************
	// fields, cylinder copies and precompensation threshold
	// ************************************************************
	assign SIZE_DRIVE_HEAD_SELECT             = dtf_pkg::dtf_sdh_s'(sdh_r);
	assign SECTOR_SIZE_SEL = sdh_r[dtf_pkg::SDH_SIZE_HI:dtf_pkg::SDH_SIZE_LO];
	assign SIZE_RESERVED   = SECTOR_SIZE_SEL == dtf_pkg::SIZE_RSV;
	wire [1:0] drv      = sdh_r[dtf_pkg::SDH_DRV_HI:dtf_pkg::SDH_DRV_LO];
	logic [9:0] cyl_copy;
	logic [3:0] cyl_ok_r;
	logic       cyl_ok_q_r;
	// unwritten copies read as zero rather than unknown
	always_ff @(posedge CLK) begin
		if (RST) begin
			cyl_ok_r   <= 4'h0;
			cyl_ok_q_r <= 1'b0;
		end else if (CE) begin
			if (cyl_wr) cyl_ok_r[drv] <= 1'b1;
			cyl_ok_q_r <= cyl_ok_r[drv];
		end
	end
	dtf_cyl_mem #(.DEPTH(4), .AW(2)) u_cyl (
		.clk   (CLK),
		.ce    (CE),
		.we    (cyl_wr),
		.waddr (drv),
		.wdata ({wr_edge && ADDR == dtf_pkg::ADR_CYLHI ? DIN[1:0]
		         : cylhi_r[1:0],
		         wr_edge && ADDR == dtf_pkg::ADR_CYLLO ? DIN : cyllo_r}),
		.raddr (drv),
		.rdata (cyl_copy)
	);
	assign TARGET_CYLINDER = cyl_ok_q_r ? cyl_copy : 10'h000;
	wire above = TARGET_CYLINDER >= {pre_r, 2'b00};
	assign REDUCED_WRITE_CURRENT = above;
	assign PRECOMP_ENABLE        = above;

	// ************************************************************
	// write gate window
	// ************************************************************
	logic       wg_r, sect_ok_r;
	logic [1:0] rot_r;
	always_ff @(posedge CLK) begin
		if (RST) begin
			wg_r <= 1'b0;
			sect_ok_r <= 1'b0;
			rot_r <= 2'h0;
		end else if (CE) begin
			if (!wg_r) begin
				// a cut gate stays off until the request drops
				wg_r <= WRITE_REQ && !rot_r[1];
				sect_ok_r <= 1'b0;
				if (!WRITE_REQ || !rot_r[1]) rot_r <= 2'h0;
			end else begin
				if (SECTOR_TIME_DONE) sect_ok_r <= 1'b1;
				if (ROTATION_PULSE && !rot_r[1]) rot_r <= rot_r + 2'h1;
				// held one sector minimum, cut at two rotations
				if ((!WRITE_REQ && sect_ok_r) || rot_r == 2'h2) begin
					wg_r <= 1'b0;
				end
			end
		end
	end
	assign WRITE_GATE = wg_r;

	// ************************************************************
	// stepper; drive-selected inputs deliberately unused
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_PULSE = 3'b011,
		ST_SPACE = 3'b010, ST_SETTLE = 3'b110
	} dtf_step_e;
	dtf_step_e st_r;
	logic [15:0] tmr_r;
	logic [9:0]  left_r;
	logic [7:0]  idx_cnt_r;
	logic        dir_r, auto_r, to_r, done_r;
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_r <= ST_IDLE;
			tmr_r <= 16'h0000;
			left_r <= 10'h000;
			idx_cnt_r <= 8'h00;
			dir_r <= 1'b0;
			auto_r <= 1'b0;
			to_r <= 1'b0;
			done_r <= 1'b0;
		end else if (CE) begin
			done_r <= 1'b0;
			tmr_r <= tmr_r + 16'h0001;
			case (st_r)
			ST_IDLE: if (SEEK_START && SEEK_COUNT != 10'h000) begin
				dir_r <= SEEK_OUT;
				auto_r <= AUTO_RESTORE;
				left_r <= SEEK_COUNT;
				to_r <= 1'b0;
				tmr_r <= 16'h0000;
				st_r <= ST_SETUP;
			end
			ST_SETUP: if (tmr_r >= 16'(dtf_pkg::DIR_SETUP_CYC)) begin
				tmr_r <= 16'h0000;
				st_r <= ST_PULSE;
			end
			ST_PULSE: if (tmr_r >= 16'(dtf_pkg::STEP_WIDTH_CYC - 1)) begin
				tmr_r <= 16'h0000;
				left_r <= left_r - 10'h001;
				idx_cnt_r <= 8'h00;
				st_r <= (left_r == 10'h001) ? ST_SETTLE : ST_SPACE;
			end
			ST_SPACE: if (auto_r ? seek_cmp_s
			          : tmr_r >= 16'(STEP_SPACE_CYC)) begin
				tmr_r <= 16'h0000;
				st_r <= ST_PULSE;
			end
			ST_SETTLE: begin
				if (idx_edge) idx_cnt_r <= idx_cnt_r + 8'h01;
				if (seek_cmp_s || idx_cnt_r ==
				    8'(dtf_pkg::SETTLE_INDEX - 1)) begin
					to_r <= !seek_cmp_s;
					done_r <= 1'b1;
					st_r <= ST_IDLE;
				end
			end
			default: st_r <= ST_IDLE;
			endcase
		end
	end
	assign STEP          = st_r == ST_PULSE;
	assign DIRECTION_OUT = dir_r;
	assign SEEK_TIMEOUT  = to_r;
	assign SEEK_DONE     = done_r;

	// ************************************************************
	// link domain: timing clock divider and per-drive write data
	// ************************************************************
	logic [1:0] wrst_r;
	logic [5:0] tdiv_r;
	logic       pc1_r, pc2_r;
	logic [3:0] wd_r, wd_d_r;
	always_ff @(posedge WCLK) begin
		wrst_r <= {wrst_r[0], RST};
		pc1_r  <= PRECOMP_ENABLE;
		pc2_r  <= pc1_r;
		if (wrst_r[1]) begin
			tdiv_r <= 6'h00;
			wd_r   <= 4'h0;
			wd_d_r <= 4'h0;
		end else begin
			tdiv_r <= tdiv_r + 6'h01;
			wd_r   <= MFM_WDATA_RAW;
			wd_d_r <= wd_r;
		end
	end
	// delay granularity is one link clock, standing in for the fixed shift
	wire [3:0] wd_out = pc2_r ? wd_d_r : wd_r;
	assign MFM_WDATA_P  = wd_out;
	assign MFM_WDATA_N  = ~wd_out;
	assign TIMING_CLK_P = {4{tdiv_r[5]}};
	assign TIMING_CLK_N = ~{4{tdiv_r[5]}};

	// ************************************************************
	// checks
	// ************************************************************
	chk_cmd_clears_irq: assert property (@(posedge CLK) disable iff (RST)
		CE && cmd_wr && !CMD_DONE |=> !INTERRUPT_REQUEST_OUT)
		else $error("command write left interrupt set");
	chk_stat_clears_irq: assert property (@(posedge CLK) disable iff (RST)
		CE && stat_rd && !CMD_DONE |=> !INTERRUPT_REQUEST_OUT)
		else $error("status read left interrupt set");
	chk_stat_readonly: assert property (@(posedge CLK) disable iff (RST)
		CE && wr_edge && top_cmd && !CMD_DONE |=> stat_r == dtf_pkg::STAT_BUSY)
		else $error("host write altered status");
	chk_done_loads: assert property (@(posedge CLK) disable iff (RST)
		CE && CMD_DONE |=> stat_r == $past(CMD_STATUS) && irq_r)
		else $error("status not loaded at finish");
	chk_scnt_dec: assert property (@(posedge CLK) disable iff (RST)
		CE && SECTOR_DONE && scnt_r != 8'h00
		&& !(wr_edge && ADDR == dtf_pkg::ADR_SCNT)
		|=> scnt_r == $past(scnt_r) - 8'h01)
		else $error("sector count did not decrement");
	sequence s_setup;
		st_r == ST_SETUP ##1 st_r == ST_PULSE;
	endsequence
	chk_dir_setup: assert property (@(posedge CLK) disable iff (RST)
		CE && st_r == ST_IDLE && SEEK_START && SEEK_COUNT != 10'h000
		|=> (st_r == ST_SETUP)[*7] ##1 s_setup)
		else $error("direction setup too short");
	chk_step_width: assert property (@(posedge CLK) disable iff (RST)
		$rose(STEP) |-> tmr_r == 16'h0000)
		else $error("step width count not restarted");
	chk_precomp_thr: assert property (@(posedge CLK) disable iff (RST)
		PRECOMP_ENABLE == (TARGET_CYLINDER >= {pre_r, 2'b00}))
		else $error("precomp threshold wrong");
	chk_wg_limit: assert property (@(posedge CLK) disable iff (RST)
		CE && wg_r && rot_r == 2'h2 |=> !wg_r)
		else $error("write gate beyond two rotations");
endmodule : dtf_task_file

/* File: tb/dtf_drive_model.sv */
// behavioural drive on the far side of the control cable
`timescale 1ns/1ps
module dtf_drive_model #(
	parameter int SPACE_NS = 800
) (
	input  wire logic STEP,
	input  wire logic DIRECTION_OUT,
	input  wire logic AUTO,
	output logic      SEEK_COMPLETE_PIN,
	output logic      INDEX_PIN
);
	int  steps = 0;
	int  viol = 0;
	time t_dir = 0;
	time t_up = 0;
	time t_dn = 0;
	initial begin
		SEEK_COMPLETE_PIN = 1'b1;
		INDEX_PIN = 1'b0;
	end
	// one index pulse per rotation of 40 us
	always begin
		#39600 INDEX_PIN = 1'b1;
		#400 INDEX_PIN = 1'b0;
	end
	always @(DIRECTION_OUT) t_dir = $time;
	always @(posedge STEP) begin
		steps++;
		t_up = $time;
		if ($time - t_dir < 250) viol++;
		if (AUTO && !SEEK_COMPLETE_PIN) viol++;
		if (!AUTO && t_dn > 0 && $time - t_dn < SPACE_NS) viol++;
		// scheduled, not blocking: programmed steps may overlap the settle
		SEEK_COMPLETE_PIN <= #2000 1'b0;
	end
	// settles 10 us after the latest step, not after each one
	always #100 begin
		if (!SEEK_COMPLETE_PIN && $time - t_up >= 10000)
			SEEK_COMPLETE_PIN = 1'b1;
	end
	always @(negedge STEP) begin
		t_dn = $time;
		if ($time - t_up < 5000) viol++;
	end
endmodule : dtf_drive_model

/* File: tb/dtf_task_file_tb.sv */
// self-checking bench for the disk task file block
`timescale 1ns/1ps
module dtf_task_file_tb;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic       clk = 1'b0;
	logic       wclk = 1'b0;
	logic       rst = 1'b1;
	logic       cs_n = 1'b1;
	logic       sel_n = 1'b0;
	logic       rd_n = 1'b1;
	logic       wr_n = 1'b1;
	logic       sdh_top = 1'b1;
	logic       done = 1'b0;
	logic       sec_done = 1'b0;
	logic       buf_req = 1'b0;
	logic       wreq = 1'b0;
	logic       st_done = 1'b0;
	logic       rot = 1'b0;
	logic       seek_go = 1'b0;
	logic       seek_out = 1'b0;
	logic       auto = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] din = 8'h00;
	logic [7:0] stat = 8'h00;
	logic [7:0] fault = 8'h00;
	logic [7:0] brd = 8'h00;
	logic [9:0] seek_n = 10'h000;
	logic [3:0] dsel = 4'h0;
	logic [3:0] raw = 4'h0;
	logic [7:0] dout, bwd, rq, last_wd;
	logic       oe_n, irq, data_request_line, b_rd, b_wr, wgate, step, dir, tmo, sdone;
	logic       reduced_write_current, pce, srsv, skc, idx;
	logic [9:0] tcyl;
	logic [1:0] ssz;
	logic [3:0] wp, wn, tp, tn;
	dtf_pkg::dtf_sdh_s size_drive_head_select;
	int         errors = 0;
	int         checked = 0;
	int         cyc = 0;
	int         n_rd = 0;
	int         n_wr = 0;
	int         wcn = 0;
	int         wl = 0;
	int         tper = 0;

	always #20 clk = ~clk;
	initial #3 forever #7.5 wclk = ~wclk;
	always @(posedge wclk) wcn++;
	always @(posedge tp[0]) begin
		tper = wcn - wl;
		wl = wcn;
	end
	always @(posedge clk) begin
		n_rd += int'(b_rd);
		n_wr += int'(b_wr);
		if (b_wr) last_wd = bwd;
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end

	dtf_task_file #(.STEP_SPACE_CYC(20)) dut (
		.CLK(clk), .RST(rst), .CE(1'b1), .WCLK(wclk), .CS_N(cs_n),
		.ADDR(addr), .RD_N(rd_n), .WR_N(wr_n), .DIN(din), .DOUT(dout),
		.DOUT_OE_N(oe_n), .SDH_AT_TOP(sdh_top),
		.INTERRUPT_REQUEST_OUT(irq), .DATA_REQUEST_LINE(data_request_line),
		.CMD_DONE(done), .CMD_STATUS(stat), .CMD_FAULT(fault),
		.SECTOR_DONE(sec_done), .BUF_REQ(buf_req), .BUF_RD(b_rd),
		.BUF_WR(b_wr), .BUF_WDATA(bwd), .BUF_RDATA(brd),
		.WRITE_REQ(wreq), .SECTOR_TIME_DONE(st_done),
		.ROTATION_PULSE(rot), .WRITE_GATE(wgate), .SEEK_START(seek_go),
		.SEEK_COUNT(seek_n), .SEEK_OUT(seek_out), .AUTO_RESTORE(auto),
		.SEEK_COMPLETE_PIN(skc), .INDEX_PIN(idx), .STEP(step),
		.DIRECTION_OUT(dir), .SEEK_TIMEOUT(tmo), .SEEK_DONE(sdone),
		.REDUCED_WRITE_CURRENT(reduced_write_current), .PRECOMP_ENABLE(pce),
		.TARGET_CYLINDER(tcyl), .SIZE_DRIVE_HEAD_SELECT(size_drive_head_select), .SECTOR_SIZE_SEL(ssz),
		.SIZE_RESERVED(srsv), .DRIVE_SELECTED_IN(dsel),
		.MFM_WDATA_RAW(raw), .MFM_WDATA_P(wp), .MFM_WDATA_N(wn),
		.TIMING_CLK_P(tp), .TIMING_CLK_N(tn)
	);
	dtf_drive_model drv (
		.STEP(step), .DIRECTION_OUT(dir), .AUTO(auto),
		.SEEK_COMPLETE_PIN(skc), .INDEX_PIN(idx)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic cmp_v(input logic [9:0] got, input logic [9:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_v
	task automatic cmp_1(input logic got, input logic exp, input string what);
		cmp_v({9'h000, got}, {9'h000, exp}, what);
	endtask : cmp_1
	task automatic cmp_n(input int got, input int exp, input string what);
		checked++;
		if (got != exp) begin
			errors++;
			$display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask : cmp_n
	// strobes held 6 cycles each way, past the two-flop synchroniser
	task automatic acc(input logic w, input logic [2:0] a,
		input logic [7:0] d);
		@(negedge clk);
		cs_n = sel_n;
		addr = a;
		din = d;
		rd_n = w;
		wr_n = ~w;
		repeat (6) @(negedge clk);
		rq = dout;
		if (!w) cmp_1(oe_n, cs_n, "read drive enable");
		rd_n = 1'b1;
		wr_n = 1'b1;
		repeat (6) @(negedge clk);
		cs_n = 1'b1;
	endtask : acc
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		repeat (3) @(negedge clk);
	endtask : pulse

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = {1'b1, 2'(i), 2'(3 - i), 3'(i + 4)};
			dsel = 4'(~i);
			acc(1'b1, dtf_pkg::ADR_SDH, v);
			acc(1'b0, dtf_pkg::ADR_SDH, 8'h00);
			cmp_v({2'h0, rq}, {2'h0, v}, "sdh readback");
			cmp_v({2'h0, size_drive_head_select}, {2'h0, v}, "sdh fields");
			cmp_v({8'h00, ssz}, {8'h00, 2'(i)}, "size select");
			cmp_1(srsv, i == 2, "size reserved");
		end
		acc(1'b1, dtf_pkg::ADR_SNUM, 8'h5a);
		sel_n = 1'b1;
		acc(1'b1, dtf_pkg::ADR_SNUM, 8'h33);
		sel_n = 1'b0;
		acc(1'b0, dtf_pkg::ADR_SNUM, 8'h00);
		cmp_v({2'h0, rq}, 10'h05a, "deselected write");
	endtask : t_regs
	task automatic t_cyl;
		for (int d = 0; d < 2; d++) begin
			acc(1'b1, dtf_pkg::ADR_SDH, {3'h0, 2'(d), 3'h0});
			acc(1'b1, dtf_pkg::ADR_CYLLO, 8'(8'h12 + 2 * d));
			acc(1'b1, dtf_pkg::ADR_CYLHI, 8'(8'hfe - d));
		end
		acc(1'b1, dtf_pkg::ADR_SDH, 8'h00);
		cmp_v(tcyl, 10'h212, "cylinder drive 1");
		acc(1'b1, dtf_pkg::ADR_SDH, 8'h08);
		cmp_v(tcyl, 10'h114, "cylinder drive 2");
		acc(1'b1, dtf_pkg::ADR_ERRPRE, 8'h45);
		cmp_1(reduced_write_current, 1'b1, "current at threshold");
		cmp_1(pce, 1'b1, "precomp at threshold");
		acc(1'b1, dtf_pkg::ADR_ERRPRE, 8'h46);
		cmp_1(reduced_write_current, 1'b0, "current below threshold");
		cmp_1(pce, 1'b0, "precomp below threshold");
	endtask : t_cyl
	task automatic t_stat;
		sdh_top = 1'b0;
		stat = 8'h51;
		fault = 8'h24;
		pulse(done);
		cmp_1(irq, 1'b1, "irq after finish");
		acc(1'b0, dtf_pkg::ADR_SDH, 8'h00);
		cmp_v({2'h0, rq}, 10'h051, "status loaded");
		cmp_1(irq, 1'b0, "irq after status read");
		acc(1'b0, dtf_pkg::ADR_ERRPRE, 8'h00);
		cmp_v({2'h0, rq}, 10'h024, "fault detail");
		pulse(done);
		acc(1'b1, dtf_pkg::ADR_SDH, 8'h70);
		cmp_1(irq, 1'b0, "irq after command");
		acc(1'b0, dtf_pkg::ADR_SDH, 8'h00);
		cmp_v({2'h0, rq}, {2'h0, dtf_pkg::STAT_BUSY}, "status busy");
		sdh_top = 1'b1;
		acc(1'b0, dtf_pkg::ADR_SDH, 8'h00);
		cmp_v({2'h0, rq}, 10'h008, "sdh kept");
	endtask : t_stat
	task automatic t_scnt;
		acc(1'b1, dtf_pkg::ADR_SCNT, 8'h02);
		for (int i = 0; i < 3; i++) begin
			pulse(sec_done);
			acc(1'b0, dtf_pkg::ADR_SCNT, 8'h00);
			cmp_v({2'h0, rq}, 10'((i < 2) ? 1 - i : 0), "count");
		end
	endtask : t_scnt
	// host touches the data port with and without a transfer requested
	task automatic t_data;
		int w0;
		int r0;
		buf_req = 1'b1;
		brd = 8'h9c;
		w0 = n_wr;
		r0 = n_rd;
		acc(1'b1, dtf_pkg::ADR_DATA, 8'hc3);
		cmp_1(data_request_line, 1'b1, "data request");
		cmp_n(n_wr - w0, 1, "bytes written");
		cmp_v({2'h0, last_wd}, 10'h0c3, "buffer byte");
		acc(1'b0, dtf_pkg::ADR_DATA, 8'h00);
		cmp_v({2'h0, rq}, 10'h09c, "data read");
		cmp_n(n_rd - r0, 1, "bytes read");
		buf_req = 1'b0;
		acc(1'b1, dtf_pkg::ADR_DATA, 8'h11);
		cmp_n(n_wr - w0, 1, "write without request");
	endtask : t_data
	task automatic t_seek(input logic o, input logic au, input int n);
		int s0;
		int k;
		s0 = drv.steps;
		k = 0;
		@(negedge clk);
		seek_out = o;
		auto = au;
		seek_n = 10'(n);
		pulse(seek_go);
		while (sdone !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		cmp_n(k < 5000 ? 1 : 0, 1, "seek finished");
		cmp_n(drv.steps - s0, n, "step count");
		cmp_1(dir, o, "direction");
		cmp_1(tmo, 1'b0, "settle limit");
	endtask : t_seek
	task automatic t_wgate;
		wreq = 1'b1;
		repeat (4) @(negedge clk);
		wreq = 1'b0;
		repeat (4) @(negedge clk);
		cmp_1(wgate, 1'b1, "gate before sector end");
		pulse(st_done);
		cmp_1(wgate, 1'b0, "gate after sector");
		wreq = 1'b1;
		pulse(rot);
		cmp_1(wgate, 1'b1, "gate after one turn");
		pulse(rot);
		cmp_1(wgate, 1'b0, "gate after two turns");
		wreq = 1'b0;
	endtask : t_wgate
	task automatic t_link;
		@(negedge clk);
		raw = 4'h6;
		repeat (300) @(negedge clk);
		cmp_n(tper, dtf_pkg::TCLK_DIV, "timing clock period");
		cmp_v({6'h00, tn}, {6'h00, ~tp}, "timing complement");
		cmp_v({6'h00, wp}, 10'h006, "write data true");
		cmp_v({6'h00, wn}, 10'h009, "write data inverse");
	endtask : t_link

	task automatic test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_regs();
		t_cyl();
		t_stat();
		t_scnt();
		t_data();
		t_seek(1'b1, 1'b0, 3);
		t_seek(1'b0, 1'b0, 2);
		t_seek(1'b1, 1'b1, 2);
		cmp_n(drv.viol, 0, "drive timing");
		t_wgate();
		t_link();
		test_done();
	end
endmodule : dtf_task_file_tb
